// File: adc_control_defines.vh
// Purpose: Constants for the converter control and result block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   Offsets, fields, reset values and timing counts
// What this block does
// - Clock select: 000 /2, 001 /8, 010 /32, 100 /4, 101 /16, 110 /64, x11 RC.
// - Channel 000-010 analog inputs, 110 temperature, 111 reference buffer.
// - Channel codes 011, 100, 101 connect nothing.
// - Writing go while enabled starts; go reads one while converting.
// - Hardware clears go when a conversion completes.
// - Clearing go mid-conversion stops it, stores partial result, no flag.
// - With enable zero, go reads zero and nothing converts.
// - Enable one powers the converter; zero powers it down.
// - Result is eight bits filling the result register.
// - Control: clock select 7:5, channel 4:2, go 1, enable 0.
// - Normal completion sets done flag and updates result.
// - A conversion takes nine and a half bit periods.
// - RC clock adds one instruction cycle before conversion begins.
`ifndef ADC_CONTROL_DEFINES_VH
`define ADC_CONTROL_DEFINES_VH

// ==========================================================
// Register offsets
`define ADDR_CONTROL     4'h0
`define ADDR_RESULT      4'h1
`define ADDR_IRQ_STATUS  4'h2
`define ADDR_IRQ_MASK    4'h3

// ==========================================================
// Control field positions
`define CS_HI            7
`define CS_LO            5
`define CH_HI            4
`define CH_LO            2
`define GO_BIT           1
`define EN_BIT           0
`define CONTROL_RESET    8'h00

// ==========================================================
// Clock selector codes
`define CS_DIV2          3'h0
`define CS_DIV8          3'h1
`define CS_DIV32         3'h2
`define CS_DIV4          3'h4
`define CS_DIV16         3'h5
`define CS_DIV64         3'h6

// ==========================================================
// Channel selector codes
`define CH_AIN0          3'h0
`define CH_AIN1          3'h1
`define CH_AIN2          3'h2
`define CH_TEMP          3'h6
`define CH_FVR           3'h7

// ==========================================================
// Timing: half bit periods per conversion, instruction cycle
`define HALF_PERIODS     5'h13
`define INSTR_CYCLE_NS   40
`define CLK_PERIOD_NS    10
`define INSTR_CYCLES     ((`INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: conv_clock_gen.v
// Purpose: Half bit period tick generator for the conversion clock
// Assumes: RC clock input is already synchronised to clk
// Notes:   Tick marks each half of a bit conversion period
`timescale 1ns/1ps
`include "adc_control_defines.vh"

module conv_clock_gen
(
    input  wire       clk,
    input  wire       rst,
    input  wire       run,
    input  wire [2:0] conv_clock_select,
    input  wire       rc_edge,
    output reg        half_tick
);

    reg  [5:0] count;
    reg  [5:0] limit;
    wire       use_rc;

    // Half period length in system clocks, minus one
    assign use_rc = (conv_clock_select[1:0] == 2'b11);
    always @*
    begin
        case (conv_clock_select)
            `CS_DIV2:  limit = 6'h00;
            `CS_DIV4:  limit = 6'h01;
            `CS_DIV8:  limit = 6'h03;
            `CS_DIV16: limit = 6'h07;
            `CS_DIV32: limit = 6'h0f;
            `CS_DIV64: limit = 6'h1f;
            default:   limit = 6'h00;
        endcase
    end

    // Divider counter, or RC edges when the RC clock is picked
    always @(posedge clk)
    begin
        if (rst || !run)
        begin
            count     <= 6'h00;
            half_tick <= 1'b0;
        end
        else if (use_rc)
        begin
            count     <= 6'h00;
            half_tick <= rc_edge;
        end
        else if (count >= limit)
        begin
            count     <= 6'h00;
            half_tick <= 1'b1;
        end
        else
        begin
            count     <= count + 6'h01;
            half_tick <= 1'b0;
        end
    end

endmodule // conv_clock_gen

// File: adc_control_and_result.v
// Purpose: Control register, sequencer and result of an 8-bit SAR converter
// Assumes: Comparator answers within one half bit period
// Notes:   Analog mux, sample-and-hold and comparator sit outside
//          The comparator answer needs three clocks to reach the SAR:
//          one for the registered trial code and two for its
//          synchroniser. Divide by two gives only two clocks per bit
//          trial, so results taken with it are not exact; use a
//          slower conversion clock when the value matters.
//          The RC clock pin is sampled as a plain level; only its
//          synchronised rising edges count as half bit periods.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "adc_control_defines.vh"

module adc_control_and_result
#(
    parameter DATA_W = 8
)
(
    input  wire              clk,
    input  wire              rst,
    input  wire [3:0]        addr,
    input  wire [DATA_W-1:0] wdata,
    input  wire              wr,
    input  wire              rd,
    output reg  [DATA_W-1:0] rdata,
    input  wire              dedicated_rc_clock,
    input  wire              comparator_in,
    output reg               converter_power,
    output reg  [4:0]        channel_connect,
    output reg               sample_hold,
    output reg  [DATA_W-1:0] dac_code,
    output reg               irq
);

    // ======================================================
    // State encoding
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_DELAY = 4'b0010;
    localparam [3:0] ST_CONV  = 4'b0100;
    localparam [3:0] ST_END   = 4'b1000;

    // Last count of the RC start delay
    localparam integer DELAY_LAST = `INSTR_CYCLES - 1;

    // Control register fields as software wrote them, except go, which only a start sets and completion clears
    reg  [2:0]        conv_clock_select;
    reg  [2:0]        channel_select;
    reg               go;
    reg               converter_enable;

    // Result and interrupt state
    reg  [DATA_W-1:0] conversion_result;
    reg               conv_done_flag;
    reg               done_mask;

    // Sequencer state
    reg  [3:0]        state;
    reg  [4:0]        half_count;
    reg  [DATA_W-1:0] sar;
    reg  [2:0]        delay_count;

    // Two-stage synchronisers, plus edge history for the RC pin
    reg               rc_s1;
    reg               rc_s2;
    reg               rc_s3;
    reg               cmp_s1;
    reg               cmp_s2;

    // Decoded strobes
    wire              half_tick;
    wire              rc_edge;
    wire              wr_ctrl;
    wire              go_write;
    wire              abort;
    wire              finish;
    wire [2:0]        bit_idx;

    // Any write to the control register
    assign wr_ctrl  = wr && (addr == `ADDR_CONTROL);
    // Start only on a go write while already enabled
    assign go_write = wr_ctrl && wdata[`GO_BIT] && converter_enable
                      && wdata[`EN_BIT];
    // Clearing go or enable while busy stops the conversion
    assign abort    = (state != ST_IDLE) && wr_ctrl
                      && (!wdata[`GO_BIT] || !wdata[`EN_BIT]);
    // Last half period of the conversion
    assign finish   = (state == ST_CONV) && half_tick
                      && (half_count == `HALF_PERIODS - 5'h01);
    // Rising edge of the synchronised RC clock
    assign rc_edge  = rc_s2 && !rc_s3;
    // One below the bit under trial, counted down from the top
    assign bit_idx  = 3'h7 - half_count[3:1];

    // ======================================================
    // Synchronisers for the RC clock and comparator
    // Only the second stage reads the first, so a metastable
    // sample settles before any logic sees it
    always @(posedge clk)
    begin
        if (rst)
        begin
            rc_s1  <= 1'b0;
            rc_s2  <= 1'b0;
            rc_s3  <= 1'b0;
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end
        else
        begin
            rc_s1  <= dedicated_rc_clock;
            rc_s2  <= rc_s1;
            rc_s3  <= rc_s2;
            cmp_s1 <= comparator_in;
            cmp_s2 <= cmp_s1;
        end
    end

    conv_clock_gen u_clk
    (
        .clk               (clk),
        .rst               (rst),
        .run               (state == ST_CONV),
        .conv_clock_select (conv_clock_select),
        .rc_edge           (rc_edge),
        .half_tick         (half_tick)
    );

    // ======================================================
    // Control register
    always @(posedge clk)
    begin
        if (rst)
        begin
            conv_clock_select <= 3'h0;
            channel_select    <= 3'h0;
            converter_enable  <= 1'b0;
            go                <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                conv_clock_select <= wdata[`CS_HI:`CS_LO];
                channel_select    <= wdata[`CH_HI:`CH_LO];
                converter_enable  <= wdata[`EN_BIT];
            end
            // Completion wins over a write in the same cycle, so go
            // never stays set for a conversion that has ended
            if (finish)
                go <= 1'b0;
            else if (wr_ctrl)
                go <= go_write;
        end
    end

    // ======================================================
    // Conversion sequencer
    always @(posedge clk)
    begin
        if (rst)
        begin
            state       <= ST_IDLE;
            half_count  <= 5'h00;
            sar         <= {DATA_W{1'b0}};
            delay_count <= 3'h0;
        end
        else
        begin
            case (state)
                // Idle, or the one-clock wind-down after a stop; both
                // take a new start, so a go written in the wind-down
                // is not lost while go already reads one
                ST_IDLE,
                ST_END:
                begin
                    half_count <= 5'h00;
                    state      <= ST_IDLE;
                    if (go_write)
                    begin
                        sar         <= {DATA_W{1'b0}};
                        delay_count <= 3'h0;
                        // RC clock waits one instruction time first
                        if (wdata[`CS_LO+1:`CS_LO] == 2'b11)
                            state <= ST_DELAY;
                        else
                            state <= ST_CONV;
                    end
                end
                ST_DELAY:
                begin
                    // Fixed wait before the first RC half period
                    if (abort)
                        state <= ST_END;
                    else if (delay_count == DELAY_LAST[2:0])
                        state <= ST_CONV;
                    else
                        delay_count <= delay_count + 3'h1;
                end
                ST_CONV:
                begin
                    // A stop request wins over a pending half tick
                    if (abort)
                        state <= ST_END;
                    else if (half_tick)
                    begin
                        half_count <= half_count + 5'h01;
                        // Odd half ends a bit trial; keep or drop the bit
                        if (half_count[0] && half_count >= 5'h03
                            && half_count <= 5'h11)
                            sar[bit_idx + 3'h1] <= cmp_s2;
                        if (finish)
                            state <= ST_END;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ======================================================
    // Result, done flag and mask
    always @(posedge clk)
    begin
        if (rst)
        begin
            conversion_result <= {DATA_W{1'b0}};
            conv_done_flag    <= 1'b0;
            done_mask         <= 1'b0;
        end
        else
        begin
            if (finish)
                conversion_result <= sar;
            // An abort keeps the bits decided so far; untried bits are 0
            else if (abort)
                conversion_result <= sar;
            // Software may also write the result register directly
            else if (wr && addr == `ADDR_RESULT)
                conversion_result <= wdata;
            // Set wins over a write-one clear
            if (finish)
                conv_done_flag <= 1'b1;
            else if (wr && addr == `ADDR_IRQ_STATUS && wdata[0])
                conv_done_flag <= 1'b0;
            // Mask bit for the single interrupt
            if (wr && addr == `ADDR_IRQ_MASK)
                done_mask <= wdata[0];
        end
    end

    // ======================================================
    // Analog side drive and read port
    always @(posedge clk)
    begin
        if (rst)
        begin
            converter_power <= 1'b0;
            channel_connect <= 5'h00;
            sample_hold     <= 1'b0;
            dac_code        <= {DATA_W{1'b0}};
            irq             <= 1'b0;
            rdata           <= {DATA_W{1'b0}};
        end
        else
        begin
            // Power follows the enable bit one clock later
            converter_power <= converter_enable;
            // Reserved codes leave every switch open
            case (channel_select)
                `CH_AIN0: channel_connect <= 5'h01;
                `CH_AIN1: channel_connect <= 5'h02;
                `CH_AIN2: channel_connect <= 5'h04;
                `CH_TEMP: channel_connect <= 5'h08;
                `CH_FVR:  channel_connect <= 5'h10;
                default:  channel_connect <= 5'h00;
            endcase
            // Hold once conversion runs; trial code sets the bit under test
            // Each trial stands for two half periods, the decided bits
            // of the SAR kept above it
            sample_hold <= (state == ST_CONV);
            if (state == ST_CONV && half_count >= 5'h02
                && half_count <= 5'h11)
                dac_code <= sar | ({{(DATA_W-1){1'b0}}, 1'b1}
                                   << (3'h7 - ((half_count[3:1])
                                   - 3'h1)));
            else
                dac_code <= {DATA_W{1'b0}};
            // Level interrupt, one clock behind the flag
            irq <= conv_done_flag && done_mask;
            // Read data stands only in the cycle after the strobe
            if (rd)
            begin
                case (addr)
                    `ADDR_CONTROL:    rdata <= {conv_clock_select,
                        channel_select, go, converter_enable};
                    `ADDR_RESULT:     rdata <= conversion_result;
                    `ADDR_IRQ_STATUS: rdata <= {7'h00, conv_done_flag};
                    `ADDR_IRQ_MASK:   rdata <= {7'h00, done_mask};
                    default:          rdata <= 8'h00;
                endcase
            end
            else
                rdata <= 8'h00;
        end
    end

endmodule // adc_control_and_result

// File: adc_control_and_result_chk.sv
// Purpose: Port checks for the converter control and result block
// Assumes: Control at 0, status at 2, mask at 3
// Notes:   Helper state mirrors what software wrote, plus abort and hold length
`timescale 1ns/1ps
module adc_control_chk
#(
    parameter DATA_W = 8
)
(
    input wire              clk,
    input wire              rst,
    input wire [3:0]        addr,
    input wire [DATA_W-1:0] wdata,
    input wire              wr,
    input wire              rd,
    input wire [DATA_W-1:0] rdata,
    input wire              converter_power,
    input wire [4:0]        channel_connect,
    input wire              sample_hold,
    input wire              irq
);
    reg  [7:0]  ctl;
    reg         msk;
    reg         abrt;
    reg  [10:0] cnt;
    wire        cw = wr && addr == 4'h0;
    // ==========================================================
    // Helper state
    function [6:0] half(input [2:0] c);
        half = (c[2] ? 7'h2 : 7'h1) << (2 * c[1:0]);
    endfunction
    function [4:0] onehot(input [2:0] c);
        onehot = c < 3'h3 ? 5'h01 << c : c == 3'h6 ? 5'h08
               : c == 3'h7 ? 5'h10 : 5'h00;
    endfunction
    // Mirror of control, mask, abort and hold length
    always @(posedge clk)
    begin
        ctl  <= rst ? 8'h00 : cw ? wdata : ctl;
        msk  <= rst ? 1'b0 : wr && addr == 4'h3 ? wdata[0] : msk;
        abrt <= rst ? 1'b0 : cw ? sample_hold && wdata[1:0] != 2'h3 : abrt;
        cnt  <= rst || !sample_hold ? 11'h000 : cnt + 11'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence ctl_written;
        cw ##1 !cw;
    endsequence
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !converter_power && !sample_hold && !irq)
        else $error("outputs active after reset");
    chk_power_follows: assert property (
        ctl_written |-> ##1 converter_power == ctl[0])
        else $error("power differs from enable");
    chk_channel_map: assert property (
        ctl_written |-> ##1 !ctl[0] || channel_connect == onehot(ctl[4:2]))
        else $error("channel connect wrong");
    chk_go_disabled: assert property (
        rd && addr == 4'h0 && !ctl[0] |=> rdata[1:0] == 2'h0)
        else $error("go or enable read while disabled");
    chk_start_ignored: assert property (
        cw && !ctl[0] |=> !sample_hold [*4])
        else $error("conversion started while disabled");
    chk_start_runs: assert property (
        cw && ctl[0] && wdata[1:0] == 2'h3 && !sample_hold
        |-> ##[1:40] sample_hold)
        else $error("start did not begin conversion");
    chk_abort_stops: assert property (
        cw && sample_hold && wdata[1:0] != 2'h3 |-> ##[1:70] !sample_hold)
        else $error("abort did not stop conversion");
    chk_conv_length: assert property (
        $fell(sample_hold) && !abrt && ctl[6:5] != 2'h3
        |-> cnt >= 18 * half(ctl[7:5]) - 3 && cnt <= 20 * half(ctl[7:5]) + 3)
        else $error("conversion length wrong");
    chk_done_irq: assert property (
        $fell(sample_hold) && !abrt && msk |-> ##[1:4] irq)
        else $error("no interrupt after completion");
endmodule // adc_control_chk

bind adc_control_and_result adc_control_chk #(.DATA_W(DATA_W)) u_chk (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .converter_power(converter_power),
    .channel_connect(channel_connect), .sample_hold(sample_hold),
    .irq(irq));

// File: analog_front_model.sv
// Purpose: Sample-and-hold and comparator stand-in
// Assumes: Bench gives the level of the selected input
// Notes:   Outside a conversion the answer flips every cycle
`timescale 1ns/1ps
module analog_front_model
(
    input  wire       clk,
    input  wire       sample_hold,
    input  wire [7:0] dac_code,
    input  wire [7:0] level,
    output wire       comparator_in
);
    reg [7:0] held = 8'h00;
    reg       flip = 1'b0;
    // ==========================================================
    // Track input while sampling, compare held value
    always @(posedge clk)
    begin
        flip <= !flip;
        held <= sample_hold ? held : level;
    end
    assign comparator_in = sample_hold ? held >= dac_code : flip;
endmodule // analog_front_model

// File: adc_control_and_result_test.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Comparator model answers from the held level
// Notes:   Sweeps every clock and channel code, then aborts
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        n_tests = n_tests + 1; \
        if ((got) !== (exp)) \
        begin \
            n_fail = n_fail + 1; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end
module adc_control_and_result_test;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [7:0]  wdata = 8'h00;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg         dedicated_rc_clock = 1'b0;
    reg  [7:0]  level = 8'h00;
    reg  [7:0]  q;
    reg  [15:0] seed = 16'h092E;
    integer     n_fail = 0;
    integer     n_tests = 0;
    integer     k;
    wire [7:0]  rdata;
    wire [7:0]  dac_code;
    wire [4:0]  channel_connect;
    wire        comparator_in;
    wire        converter_power;
    wire        sample_hold;
    wire        irq;
    adc_control_and_result dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .dedicated_rc_clock(dedicated_rc_clock),
        .comparator_in(comparator_in), .converter_power(converter_power),
        .channel_connect(channel_connect), .sample_hold(sample_hold),
        .dac_code(dac_code), .irq(irq));
    analog_front_model front (
        .clk(clk), .sample_hold(sample_hold), .dac_code(dac_code),
        .level(level), .comparator_in(comparator_in));
    // ==========================================================
    // Clocks, watchdog, helpers
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #3;
        forever #40 dedicated_rc_clock = ~dedicated_rc_clock;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail = n_fail + 1;
        conclude;
    end
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [4:0] exp_connect(input [2:0] c);
        exp_connect = c < 3'h3 ? 5'h01 << c : c == 3'h6 ? 5'h08
                    : c == 3'h7 ? 5'h10 : 5'h00;
    endfunction
    task wr_reg(input [3:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    end
    endtask
    task rd_reg(input [3:0] a, output [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    end
    endtask
    task wait_idle;
        integer i;
    begin
        rd_reg(4'h0, q);
        for (i = 0; q[1] === 1'b1; i = i + 1)
        begin
            if (i == 800)
            begin
                n_fail = n_fail + 1;
                conclude;
            end
            rd_reg(4'h0, q);
        end
    end
    endtask
    task conclude;
    begin
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'h0, q);
        `CHECK("control reset", 8'h00, q)
        wr_reg(4'h0, 8'h02);
        rd_reg(4'h0, q);
        `CHECK("go disabled", 8'h00, q)
        wr_reg(4'h0, 8'h03);
        rd_reg(4'h0, q);
        `CHECK("go with enable", 8'h01, q)
        wr_reg(4'h3, 8'h01);
        for (k = 0; k < 64; k = k + 1)
        begin
            seed = lfsr(seed);
            @(posedge clk);
            level <= k == 8 ? 8'h00 : k == 63 ? 8'hFF : seed[7:0];
            wr_reg(4'h0, {k[5:0], 2'b01});
            repeat (2) @(posedge clk);
            `CHECK("channel", exp_connect(k[2:0]), channel_connect)
            `CHECK("power", 1'b1, converter_power)
            repeat (20) @(posedge clk);
            wr_reg(4'h0, {k[5:0], 2'b11});
            rd_reg(4'h0, q);
            `CHECK("go busy", {k[5:0], 2'b11}, q)
            wait_idle;
            `CHECK("go cleared", {k[5:0], 2'b01}, q)
            rd_reg(4'h2, q);
            `CHECK("done flag", 8'h01, q)
            `CHECK("irq", 1'b1, irq)
            rd_reg(4'h1, q);
            // Divide by two is too fast for the synchronised comparator
            if ((k[2:0] < 3 || k[2:0] > 5) && k[5:3] != 0)
                `CHECK("result", level, q)
            wr_reg(4'h2, 8'h01);
        end
        $display("sweep done");
        @(posedge clk);
        level <= 8'hFF;
        wr_reg(4'h0, 8'hC5);
        repeat (20) @(posedge clk);
        wr_reg(4'h0, 8'hC7);
        repeat (300) @(posedge clk);
        wr_reg(4'h0, 8'hC5);
        repeat (70) @(posedge clk);
        rd_reg(4'h0, q);
        `CHECK("abort go", 8'hC5, q)
        rd_reg(4'h2, q);
        `CHECK("abort flag", 8'h00, q)
        rd_reg(4'h1, q);
        `CHECK("partial", 1'b1, q[7] && q != 8'hFF)
        wr_reg(4'h0, 8'hC7);
        wait_idle;
        rd_reg(4'h1, q);
        `CHECK("restart result", 8'hFF, q)
        `CHECK("irq masked on", 1'b1, irq)
        wr_reg(4'h3, 8'h00);
        rd_reg(4'h2, q);
        `CHECK("irq masked off", 1'b0, irq)
        wr_reg(4'h2, 8'h01);
        $display("abort done");
        wr_reg(4'h0, 8'hC7);
        repeat (50) @(posedge clk);
        wr_reg(4'h0, 8'hC4);
        rd_reg(4'h0, q);
        `CHECK("disabled go", 8'hC4, q)
        `CHECK("hold off", 1'b0, sample_hold)
        `CHECK("power off", 1'b0, converter_power)
        wr_reg(4'h1, 8'h5A);
        rd_reg(4'h1, q);
        `CHECK("result write", 8'h5A, q)
        rd_reg(4'h9, q);
        `CHECK("unmapped", 8'h00, q)
        $display("register test done");
        conclude;
    end
endmodule // adc_control_and_result_test
